// ===== rss_far_side.sv
// Supply detector, reset pin driver and watchdog with its oscillator
// Assumes the bench calls the tasks; the oscillator runs free
`timescale 1ns/100ps
module rss_far_side (
  input wire logic clk,
  output rss_pkg::rss_sources_t src,
  output logic wdo_tick
);
  import rss_pkg::*;
  initial begin
    src = '{1'b0, 1'b1, 1'b0, 1'b0};
    wdo_tick = 1'b0;
  end
  // Period near four clocks, drifting so phase never locks
  always #20.3 wdo_tick = ~wdo_tick;
  task automatic supply(input logic on);
    @(posedge clk);
    src.powerup_n_pin <= on;
  endtask
  task automatic pin_low(input int cycles);
    @(posedge clk);
    src.ext_reset_n_pin <= 1'b0;
    repeat (cycles) @(posedge clk);
    src.ext_reset_n_pin <= 1'b1;
  endtask
  task automatic wake();
    @(posedge clk);
    src.sleep_wake <= 1'b1;
    repeat (3) @(posedge clk);
    src.sleep_wake <= 1'b0;
  endtask
  task automatic expire();
    @(posedge clk);
    src.watchdog_expire <= 1'b1;
    repeat (3) @(posedge clk);
    src.watchdog_expire <= 1'b0;
  endtask
endmodule // rss_far_side

// ===== rss_map.svh
// Offsets, field positions, reset values and timing counts of the reset sequencer
// Assumes inclusion by name from the sequencer and the bench
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

// ----------------------------------------
// Reset-cause status register
// ----------------------------------------
`define RSS_CAUSE_ADDR 4'h0
`define RSS_POWERUP_BIT 0
`define RSS_PIN_BIT 1
`define RSS_WATCHDOG_BIT 3
`define RSS_CAUSE_RESET 8'h00

// ----------------------------------------
// Vectors
// ----------------------------------------
`define RSS_RESET_VECTOR 13'h0000
`define RSS_BOOT_VECTOR 13'h1E00
`define RSS_IRQ_BASE 13'h0002

// ----------------------------------------
// Delay selection
// ----------------------------------------
`define RSS_DELAY_SELECT_SHIPPED 3'h2
`define RSS_CK_SHORT 6
`define RSS_CK_MID 1024
`define RSS_CK_LONG 16384
`define RSS_WDO_SHORT 1024
`define RSS_WDO_LONG 16384
`define RSS_WDO_SHORT_SCALED 4096
`define RSS_WDO_LONG_SCALED 65536
`define RSS_MIN_RT_CYCLES 4
// Power-up extension of 0.6 ms, in watchdog oscillator ticks at an assumed 1 us tick
`define RSS_PWRUP_EXT_US 600
`define RSS_WDO_TICK_NS 1000
`define RSS_CLK_NS 10
// Pin reset least low time
`define RSS_PIN_MIN_NS 500

`endif

// ===== rss_pkg.sv
// Types shared by the reset sequencer modules
// Assumes rss_map.svh is on the include path
package rss_pkg;
  typedef enum logic [1:0] {
    RSS_ST_HOLD = 2'b00,
    RSS_ST_REALTIME = 2'b01,
    RSS_ST_CLOCKS = 2'b10,
    RSS_ST_RUN = 2'b11
  } rss_state_t;

  typedef struct packed {
    logic powerup_n_pin;
    logic ext_reset_n_pin;
    logic watchdog_expire;
    logic sleep_wake;
  } rss_sources_t;

  typedef struct packed {
    logic [2:0] startup_delay_select;
    logic startup_time_scale_fuse;
    logic boot_vector_select_fuse;
  } rss_fuses_t;
endpackage

// ===== rss_seq_sva.sv
// Port checker for the reset sequencer
// Assumes one clock domain and binding onto rss_sequencer
`timescale 1ns/100ps
module rss_seq_sva (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire rss_pkg::rss_sources_t SOURCES,
  input wire rss_pkg::rss_fuses_t FUSES,
  input wire logic WATCHDOG_ENABLE,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic CORE_RESET,
  input wire logic IO_INIT,
  input wire logic [12:0] FETCH_ADDR,
  input wire logic [12:0] IRQ_VECTOR_BASE,
  input wire logic WATCHDOG_PULSE
);
  import rss_pkg::*;
  logic [6:0] low_cnt_r;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || SOURCES.ext_reset_n_pin) low_cnt_r <= 7'h00;
    else if (low_cnt_r != 7'h7F) low_cnt_r <= low_cnt_r + 7'h01;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  AST_SRC_WDOG: assert property (WATCHDOG_PULSE |-> ##[0:2] CORE_RESET)
    else $error("watchdog pulse without core reset");
  AST_PIN_LOW: assert property (low_cnt_r == 7'h3C |-> ##[0:3] CORE_RESET)
    else $error("long pin low without core reset");
  AST_IO_INIT: assert property (CORE_RESET |-> IO_INIT)
    else $error("io init low during reset");
  AST_VECTOR: assert property ($fell(CORE_RESET) |->
    FETCH_ADDR == (FUSES.boot_vector_select_fuse ? 13'h1E00 : 13'h0000))
    else $error("wrong first fetch address");
  AST_IRQ_BASE: assert property (!CORE_RESET |-> IRQ_VECTOR_BASE == 13'h0002)
    else $error("interrupt base moved");
  AST_SUPPLY: assert property ($fell(SOURCES.powerup_n_pin) |-> ##[1:4] CORE_RESET)
    else $error("supply drop did not reset");
  AST_MIN_HOLD: assert property ($fell(CORE_RESET) |-> $past(CORE_RESET, 6))
    else $error("reset released too early");
  AST_RELEASE: assert property ($fell(CORE_RESET) |->
    SOURCES.powerup_n_pin && SOURCES.ext_reset_n_pin)
    else $error("released while a source is active");
  AST_WDOG_ONE: assert property (WATCHDOG_PULSE |=> !WATCHDOG_PULSE)
    else $error("watchdog pulse longer than one cycle");
  AST_WDOG_EN: assert property (WATCHDOG_PULSE |-> WATCHDOG_ENABLE && $past(WATCHDOG_ENABLE))
    else $error("watchdog pulse while disabled");
  AST_RSVD: assert property (REG_RDATA[7:4] == 4'h0 && !REG_RDATA[2])
    else $error("reserved status bits set");
  AST_RD_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside its cycle");
endmodule // rss_seq_sva

bind rss_sequencer rss_seq_sva i_chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
  .SOURCES(SOURCES), .FUSES(FUSES), .WATCHDOG_ENABLE(WATCHDOG_ENABLE), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .CORE_RESET(CORE_RESET), .IO_INIT(IO_INIT),
  .FETCH_ADDR(FETCH_ADDR), .IRQ_VECTOR_BASE(IRQ_VECTOR_BASE),
  .WATCHDOG_PULSE(WATCHDOG_PULSE));

// ===== rss_sequencer.sv
// Reset source merger and start-up delay sequencer
// Assumes one 100 MHz clock, a watchdog oscillator tick as a pin, fuses static
//
// What this block does
// RL1 - Power-on, pin and watchdog are the three reset causes; any asserts reset
// RL2 - Pin low over 500 ns resets; host must hold it at least that long
// RL3 - I/O registers load initial values in reset; fetch starts at 0x000
// RL4 - Boot fuse moves reset vector to 0x1E00; interrupt vectors stay from 0x002
// RL5 - Software puts a jump at 0x000; vectors free only without interrupts
// RL6 - Supply rise starts delay; supply fall reasserts reset at once
// RL7 - Select code gives clock part: 6, 16K or 1K system clocks
// RL8 - Select code gives real-time part: short, long or minimal
// RL9 - Real-time part counts watchdog ticks: 1K/16K, or 4K/64K when scaled
// RL10 - Waking from sleep uses only the clock-counting part
// RL11 - Select code changes delay length only, never the oscillator
// RL12 - Shipped select code is 010: long real-time plus 16K clocks
// RL13 - At power-up the real-time part is lengthened by about 0.6 ms
// RL14 - After the pin rises, release waits for the full time-out
// RL15 - Watchdog reset is a one-cycle pulse, only on enabled expiry
// RL16 - Delay starts on the trailing edge of the watchdog pulse
// RL17 - Watchdog reset sets bit 3; power-on or written zero clears it
// RL18 - Pin reset sets bit 1; power-on or written zero clears it
// RL19 - Power-on sets bit 0; only a written zero clears it
// RL20 - Reset asserts at once from any source, releases on the clock; the block asserts CORE_RESET on the clock too, after the input synchronisers
`timescale 1ns/100ps
`include "rss_map.svh"
module rss_sequencer #(
  parameter int CK_LONG = `RSS_CK_LONG,
  parameter int WDO_LONG_SCALED = `RSS_WDO_LONG_SCALED,
  parameter int WDO_LONG = `RSS_WDO_LONG,
  parameter int PWRUP_EXT = (`RSS_PWRUP_EXT_US * 1000) / `RSS_WDO_TICK_NS
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire rss_pkg::rss_sources_t SOURCES,
  input wire logic WATCHDOG_ENABLE,
  input wire logic WDO_TICK,
  input wire rss_pkg::rss_fuses_t FUSES,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic CORE_RESET,
  output logic IO_INIT,
  output logic [12:0] FETCH_ADDR,
  output logic [12:0] IRQ_VECTOR_BASE,
  output logic WATCHDOG_PULSE
);
  import rss_pkg::*;

  localparam int PIN_CYCLES = (`RSS_PIN_MIN_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS;

  initial begin
    if (CK_LONG < 16 || CK_LONG > 65535 || WDO_LONG < 4 || WDO_LONG_SCALED < 4 ||
        WDO_LONG_SCALED > 1048575 || PWRUP_EXT < 0 || PWRUP_EXT > 65535) begin
      $error("rss_sequencer: count parameter out of range");
    end
  end

  // ----------------------------------------
  // Delay selection
  // ----------------------------------------
  // Clock part depends on the code only, never on the scale fuse
  function automatic logic [19:0] ck_count(input logic [2:0] sel);
    case (sel)
      3'h0, 3'h1: ck_count = 20'(`RSS_CK_SHORT); // RL7
      3'h2, 3'h3, 3'h4: ck_count = 20'(CK_LONG); // RL7 RL12
      default: ck_count = 20'(`RSS_CK_MID); // RL7
    endcase
  endfunction

  // Real-time part in watchdog ticks
  function automatic logic [19:0] rt_count(input logic [2:0] sel, input logic scaled);
    case (sel)
      3'h0, 3'h3, 3'h6: rt_count = scaled ? 20'(`RSS_WDO_SHORT_SCALED) :
                                            20'(`RSS_WDO_SHORT); // RL8 RL9
      3'h2, 3'h5: rt_count = scaled ? 20'(WDO_LONG_SCALED) : 20'(WDO_LONG); // RL8 RL9
      default: rt_count = 20'(`RSS_MIN_RT_CYCLES); // RL8
    endcase
  endfunction

  // ----------------------------------------
  // Pin input conditioning
  // ----------------------------------------
  logic pin_low;

  rss_sync #(
    .FILTER_CYCLES(PIN_CYCLES)
  ) u_pin (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .pin_n(SOURCES.ext_reset_n_pin),
    .qual_low(pin_low)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic por1;
    logic por2;
    logic wdx1;
    logic wdx2;
    logic wdx_prev;
    logic tk1;
    logic tk2;
    logic tk_prev;
    logic sl1;
    logic sl2;
    logic sl_prev;
    logic wd_pulse;
    logic powerup_pending;
    rss_state_t state;
    logic [19:0] cnt;
    logic [7:0] cause;
    logic [7:0] rdata;
    logic core_reset;
    logic io_init;
    logic [12:0] fetch;
    logic [12:0] irq_base;
  } rss_st_t;

  rss_st_t st_r;
  rss_st_t st_nxt;

  logic tick;
  logic wd_rise;
  logic wake_rise;
  logic por_active;
  logic pin_active;

  assign tick = st_r.tk2 & ~st_r.tk_prev;
  assign wd_rise = st_r.wdx2 & ~st_r.wdx_prev & WATCHDOG_ENABLE; // RL15
  assign wake_rise = st_r.sl2 & ~st_r.sl_prev;
  assign por_active = ~st_r.por2;
  assign pin_active = pin_low; // RL2

  always_comb begin
    st_nxt = st_r;
    st_nxt.por1 = SOURCES.powerup_n_pin;
    st_nxt.por2 = st_r.por1;
    st_nxt.wdx1 = SOURCES.watchdog_expire;
    st_nxt.wdx2 = st_r.wdx1;
    st_nxt.wdx_prev = st_r.wdx2;
    st_nxt.tk1 = WDO_TICK;
    st_nxt.tk2 = st_r.tk1;
    st_nxt.tk_prev = st_r.tk2;
    st_nxt.sl1 = SOURCES.sleep_wake;
    st_nxt.sl2 = st_r.sl1;
    st_nxt.sl_prev = st_r.sl2;
    st_nxt.wd_pulse = wd_rise; // RL15
    st_nxt.rdata = 8'h00;

    // Register port: writing zero clears a flag, writing one keeps it
    if (REG_WR && REG_ADDR == `RSS_CAUSE_ADDR) begin
      st_nxt.cause[`RSS_POWERUP_BIT] = st_r.cause[`RSS_POWERUP_BIT] &
                                       REG_WDATA[`RSS_POWERUP_BIT]; // RL19
      st_nxt.cause[`RSS_PIN_BIT] = st_r.cause[`RSS_PIN_BIT] & REG_WDATA[`RSS_PIN_BIT]; // RL18
      st_nxt.cause[`RSS_WATCHDOG_BIT] = st_r.cause[`RSS_WATCHDOG_BIT] &
                                        REG_WDATA[`RSS_WATCHDOG_BIT]; // RL17
    end

    // Sources override a same-cycle clear
    if (por_active) begin
      st_nxt.cause = `RSS_CAUSE_RESET;
      st_nxt.cause[`RSS_POWERUP_BIT] = 1'b1; // RL19 RL17 RL18
    end else begin
      if (pin_active) begin
        st_nxt.cause[`RSS_PIN_BIT] = 1'b1; // RL18
      end
      if (st_r.wd_pulse) begin
        st_nxt.cause[`RSS_WATCHDOG_BIT] = 1'b1; // RL17
      end
    end

    if (REG_RD) begin
      st_nxt.rdata = (REG_ADDR == `RSS_CAUSE_ADDR) ? st_nxt.cause : 8'h00;
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    if (por_active || pin_active || st_r.wd_pulse) begin
      // RL1 RL6 RL20: any synchronised source holds reset from the next clock, with no start-up delay
      st_nxt.state = RSS_ST_HOLD;
      st_nxt.core_reset = 1'b1;
      st_nxt.io_init = 1'b1; // RL3
      st_nxt.cnt = 20'h00000;
      if (por_active) begin
        st_nxt.powerup_pending = 1'b1;
      end
    end else begin
      case (st_r.state)
        RSS_ST_HOLD: begin
          // Source gone: RL6 supply rise, RL14 pin rise, RL16 pulse trailing edge
          st_nxt.state = RSS_ST_REALTIME;
          st_nxt.cnt = rt_count(FUSES.startup_delay_select, FUSES.startup_time_scale_fuse) +
                       (st_r.powerup_pending ? 20'(PWRUP_EXT) : 20'h00000); // RL13
          st_nxt.powerup_pending = 1'b0;
        end
        RSS_ST_REALTIME: begin
          if (st_r.cnt == 20'h00000) begin
            st_nxt.state = RSS_ST_CLOCKS;
            st_nxt.cnt = ck_count(FUSES.startup_delay_select) - 20'h00001; // RL7
          end else if (tick) begin
            st_nxt.cnt = st_r.cnt - 20'h00001; // RL9
          end
        end
        RSS_ST_CLOCKS: begin
          if (st_r.cnt == 20'h00000) begin
            st_nxt.state = RSS_ST_RUN;
            st_nxt.core_reset = 1'b0; // RL14 RL20
            st_nxt.io_init = 1'b0;
            st_nxt.fetch = FUSES.boot_vector_select_fuse ? `RSS_BOOT_VECTOR :
                                                           `RSS_RESET_VECTOR; // RL3 RL4
          end else begin
            st_nxt.cnt = st_r.cnt - 20'h00001;
          end
        end
        RSS_ST_RUN: begin
          // Wake from sleep reruns the clock part with CORE_RESET held low
          if (wake_rise) begin
            st_nxt.state = RSS_ST_CLOCKS;
            st_nxt.cnt = ck_count(FUSES.startup_delay_select) - 20'h00001; // RL10
            st_nxt.core_reset = 1'b0;
          end
        end
        default: begin
          st_nxt.state = RSS_ST_HOLD;
          st_nxt.core_reset = 1'b1;
        end
      endcase
    end
    st_nxt.irq_base = `RSS_IRQ_BASE; // RL4
  end

  // SYS_RST is the synchronous local reset; the fuse inputs steer delay and the first fetch address only, RL11
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st_r <= '{por1: 1'b0, por2: 1'b0, wdx1: 1'b0, wdx2: 1'b0, wdx_prev: 1'b0,
                tk1: 1'b0, tk2: 1'b0, tk_prev: 1'b0, sl1: 1'b0, sl2: 1'b0,
                sl_prev: 1'b0, wd_pulse: 1'b0, powerup_pending: 1'b1,
                state: RSS_ST_HOLD, cnt: 20'h00000, cause: `RSS_CAUSE_RESET,
                rdata: 8'h00, core_reset: 1'b1, io_init: 1'b1,
                fetch: `RSS_RESET_VECTOR, irq_base: `RSS_IRQ_BASE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA = st_r.rdata;
  assign CORE_RESET = st_r.core_reset;
  assign IO_INIT = st_r.io_init;
  assign FETCH_ADDR = st_r.fetch;
  assign IRQ_VECTOR_BASE = st_r.irq_base;
  assign WATCHDOG_PULSE = st_r.wd_pulse;
endmodule // rss_sequencer

// ===== rss_sync.sv
// Two-stage synchroniser with a filter that qualifies a low level on a pin
// Assumes one clock domain; the input is asynchronous to it
`timescale 1ns/100ps
module rss_sync #(
  parameter int FILTER_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_n,
  output logic qual_low
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [15:0] cnt;
    logic q;
  } rss_sync_st_t;

  rss_sync_st_t st_r;
  rss_sync_st_t st_nxt;

  initial begin
    if (FILTER_CYCLES < 1 || FILTER_CYCLES > 65535) begin
      $error("rss_sync: FILTER_CYCLES out of range");
    end
  end

  // Only s2 is read beyond the first stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_n;
    st_nxt.s2 = st_r.s1;
    if (st_r.s2) begin
      st_nxt.cnt = 16'h0000;
      st_nxt.q = 1'b0;
    end else if (st_r.cnt >= 16'(FILTER_CYCLES - 1)) begin
      st_nxt.q = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{s1: 1'b1, s2: 1'b1, cnt: 16'h0000, q: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign qual_low = st_r.q;
endmodule // rss_sync

// ===== tb_rss_sequencer.sv
// Self-checking bench for the reset sequencer
// Assumes rss_map.svh on the include path and rss_far_side beside it
`timescale 1ns/100ps
`include "rss_map.svh"
module tb_rss_sequencer;
  import rss_pkg::*;
  // Clocks per oscillator tick: the modelled period lies between these two
  localparam int TK_LO = 4;
  localparam int TK_HI = 5;
  localparam int WDO_LONG = 32;
  localparam int WDO_SCALED = 64;
  localparam int PWRUP = (`RSS_PWRUP_EXT_US * 1000) / `RSS_WDO_TICK_NS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  rss_sources_t src;
  logic wdo_tick;
  logic wd_en = 1'b0;
  rss_fuses_t fuses = '{3'h2, 1'b0, 1'b0};
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic core_rst;
  logic io_init;
  logic [12:0] fetch;
  logic [12:0] irq_base;
  logic wd_pulse;
  int num_errors = 0;
  int n_checks = 0;
  int pulses = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (wd_pulse === 1'b1) pulses++;
  rss_far_side i_far (.clk(clk), .src(src), .wdo_tick(wdo_tick));
  rss_sequencer #(.WDO_LONG_SCALED(WDO_SCALED), .WDO_LONG(WDO_LONG)) i_dut (
    .CORE_CLK(clk), .SYS_RST(rst), .SOURCES(src), .WATCHDOG_ENABLE(wd_en),
    .WDO_TICK(wdo_tick), .FUSES(fuses), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .CORE_RESET(core_rst), .IO_INIT(io_init),
    .FETCH_ADDR(fetch), .IRQ_VECTOR_BASE(irq_base), .WATCHDOG_PULSE(wd_pulse));
  task automatic print_verdict();
    $display("mismatches %0d of %0d checks", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_span(input int n, input int lo, input int hi);
    cmp_val(16'(n >= lo && n <= hi), 16'h0001);
    if (n < lo || n > hi) $display("  delay %0h outside %0h..%0h", n, lo, hi);
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp_val({8'h00, rdata}, {8'h00, exp});
  endtask
  // Counts cycles until the core leaves reset; bounded so a hang ends the run
  task automatic wait_release(output int n);
    n = 0;
    while (core_rst !== 1'b0) begin
      @(posedge clk);
      #1 n++;
      if (n > 25000) begin
        num_errors++;
        print_verdict();
      end
    end
  endtask
  task automatic t_powerup();
    int n;
    int rt = WDO_LONG + PWRUP;
    i_far.supply(1'b1);
    wait_release(n);
    cmp_span(n, rt * TK_LO + `RSS_CK_LONG, rt * TK_HI + `RSS_CK_LONG + 8);
    cmp_val({3'h0, fetch}, 16'h0000);
    cmp_val({15'h0, io_init}, 16'h0000);
    reg_chk(4'h0, 8'h01);
  endtask
  task automatic t_pin();
    int n;
    fuses <= '{3'h1, 1'b0, 1'b1};
    i_far.pin_low(60);
    #1 cmp_val({15'h0, core_rst}, 16'h0001);
    cmp_val({15'h0, io_init}, 16'h0001);
    wait_release(n);
    cmp_span(n, 4 * TK_LO + 6, 4 * TK_HI + 80);
    cmp_val({3'h0, fetch}, 16'h1E00);
    cmp_val({3'h0, irq_base}, 16'h0002);
    reg_chk(4'h0, 8'h03);
  endtask
  task automatic t_scaled();
    int n;
    int rt = WDO_SCALED + PWRUP;
    fuses <= '{3'h2, 1'b1, 1'b0};
    i_far.supply(1'b0);
    repeat (10) @(posedge clk);
    #1 cmp_val({15'h0, core_rst}, 16'h0001);
    i_far.supply(1'b1);
    wait_release(n);
    cmp_span(n, rt * TK_LO + `RSS_CK_LONG, rt * TK_HI + `RSS_CK_LONG + 8);
    reg_chk(4'h0, 8'h01);
  endtask
  task automatic t_wdog();
    int n;
    fuses <= '{3'h1, 1'b0, 1'b0};
    i_far.expire();
    repeat (8) @(posedge clk);
    cmp_val(16'(pulses), 16'h0000);
    wd_en <= 1'b1;
    i_far.expire();
    repeat (8) @(posedge clk);
    cmp_val(16'(pulses), 16'h0001);
    wait_release(n);
    cmp_span(n, 8, 80);
    reg_chk(4'h0, 8'h09);
    reg_wr(4'h0, 8'hF9);
    reg_chk(4'h0, 8'h09);
    reg_wr(4'h5, 8'h00);
    reg_chk(4'h5, 8'h00);
    reg_wr(4'h0, 8'h00);
    reg_chk(4'h0, 8'h00);
  endtask
  // Wake from sleep must never pull the core back into reset
  task automatic t_wake();
    int bad;
    bad = 0;
    i_far.wake();
    repeat (40) begin
      @(posedge clk);
      #1 if (core_rst !== 1'b0 || io_init !== 1'b0) bad++;
    end
    cmp_val(16'(bad), 16'h0000);
    cmp_val({3'h0, fetch}, 16'h0000);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_powerup();
    t_pin();
    t_scaled();
    t_wdog();
    t_wake();
    print_verdict();
  end
endmodule // tb_rss_sequencer
